/* File: mies_pkg.sv */
package mies_pkg;

  // ==========================================================
  // Instruction word layout and opcode classes.
  localparam int WORD_W  = 15;
  localparam int PC_W    = 12;
  localparam int DATA_W  = 8;
  localparam int MEM_DEPTH = 160;
  localparam int STACK_DEPTH = 6;
  localparam int SP_W    = 3;

  typedef enum logic [2:0] {
    MIES_CLASS_MEM  = 3'h0,
    MIES_CLASS_IMM  = 3'h1,
    MIES_CLASS_JUMP = 3'h2,
    MIES_CLASS_CALL = 3'h3,
    MIES_CLASS_MISC = 3'h4
  } mies_class_type;

  // Memory-operand operations, in the sub field of a memory word.
  localparam logic [3:0] SUB_ADD_ONE     = 4'h0;
  localparam logic [3:0] SUB_ADD_ONE_ACC = 4'h1;
  localparam logic [3:0] SUB_COPY_TO_ACC = 4'h2;
  localparam logic [3:0] SUB_COPY_TO_MEM = 4'h3;
  localparam logic [3:0] SUB_OR_ACC      = 4'h4;
  localparam logic [3:0] SUB_OR_MEM      = 4'h5;
  localparam logic [3:0] SUB_ROT_L       = 4'h6;
  localparam logic [3:0] SUB_ROT_L_ACC   = 4'h7;
  localparam logic [3:0] SUB_ROT_LC      = 4'h8;
  localparam logic [3:0] SUB_ROT_LC_ACC  = 4'h9;
  localparam logic [3:0] SUB_ROT_R       = 4'ha;
  localparam logic [3:0] SUB_ROT_R_ACC   = 4'hb;
  localparam logic [3:0] SUB_ROT_RC      = 4'hc;
  localparam logic [3:0] SUB_ROT_RC_ACC  = 4'hd;
  // Immediate-operand operations.
  localparam logic [3:0] SUB_COPY_IMM    = 4'h0;
  localparam logic [3:0] SUB_OR_IMM      = 4'h1;
  localparam logic [3:0] SUB_RET_IMM     = 4'h2;
  // Operand-free operations.
  localparam logic [3:0] SUB_IDLE        = 4'h0;
  localparam logic [3:0] SUB_POWER_DOWN  = 4'h1;
  localparam logic [3:0] SUB_RET         = 4'h2;
  localparam logic [3:0] SUB_IRQ_RET     = 4'h3;

  typedef struct packed {
    mies_class_type opClass;
    logic [3:0]     sub;
    logic [7:0]     operand;
  } mies_instr_type;

  typedef struct packed {
    logic watchdogExpiry;
    logic sleepEntered;
    logic overflow;
    logic zero;
    logic auxCarry;
    logic carry;
  } mies_status_type;

  localparam mies_status_type STATUS_RESET = '0;

  // ==========================================================
  // Register map, byte addresses on APB.
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_ACC      = 8'h08;
  localparam logic [7:0] REG_PC       = 8'h0c;
  localparam logic [7:0] REG_IRQ_CTRL = 8'h10;
  localparam logic [7:0] REG_MEM_ADDR = 8'h14;
  localparam logic [7:0] REG_MEM_DATA = 8'h18;
  localparam int CTRL_RUN_BIT  = 0;
  localparam int IRQ_GLOBAL_EN_BIT = 0;

  // ==========================================================
  // Watchdog geometry.
  localparam int WDT_PRE_W = 8;
  localparam int WDT_CNT_W = 8;

endpackage : mies_pkg

/* File: mies_core.sv */
`timescale 1ns/1ps
// Operation
// [RULE_01] Power down halts execution; program counter rests on the next instruction.
// [RULE_02] Power down sets the sleep flag and clears the watchdog expiry flag; a watchdog expiry in the same cycle leaves the expiry flag set instead.
// [RULE_03] Power down zeroes watchdog counter and prescaler; memory and registers persist.
// [RULE_04] Add one to a memory byte in place; only zero flag changes.
// [RULE_05] Memory byte plus one goes to accumulator; memory kept; zero flag only.
// [RULE_06] Jump loads program counter from the word; no stack, no flags.
// [RULE_07] Copy memory byte to accumulator; flags unchanged.
// [RULE_08] Copy the 8-bit literal to accumulator; flags unchanged.
// [RULE_09] Copy accumulator into memory byte; flags unchanged.
// [RULE_10] Idle only advances the program counter; no flag changes.
// [RULE_11] OR memory byte or literal into accumulator; zero flag only.
// [RULE_12] OR accumulator into memory byte in place; zero flag only.
// [RULE_13] Subroutine exit pops the counter, takes two cycles, keeps flags.
// [RULE_14] Literal exit pops the counter and loads the literal into accumulator.
// [RULE_15] Interrupt exit pops the counter and sets the global interrupt enable.
// [RULE_16] Rotate memory byte left in place, bit 7 into bit 0.
// [RULE_17] Left-rotated byte to accumulator; memory and flags kept.
// [RULE_18] Rotate memory byte left through carry in place.
// [RULE_19] Left rotate through carry into accumulator; carry updated, memory kept.
// [RULE_20] Rotate memory byte right in place, bit 0 into bit 7.
// [RULE_21] Right-rotated byte to accumulator; memory and flags kept.
// [RULE_22] Rotate memory byte right through carry in place.
// [RULE_23] Counter reloads discard the prefetched word, taking two cycles.
module mies_core (
  // Clock and reset.
  input  wire  logic                          clk,
  input  wire  logic                          reset,
  // Program memory fetch port.
  output       logic [mies_pkg::PC_W-1:0]     progAddr,
  input  wire  logic [mies_pkg::WORD_W-1:0]   progWord,
  // Power down and interrupt control.
  input  wire  logic                          wakeUp,
  output       logic                          coreHalted,
  output       logic                          globalIrqEnable,
  // APB register bus.
  input  wire  logic                          psel,
  input  wire  logic                          penable,
  input  wire  logic                          pwrite,
  input  wire  logic [mies_pkg::ADDR_W-1:0]   paddr,
  input  wire  logic [31:0]                   pwdata,
  output       logic [31:0]                   prdata,
  output       logic                          pready,
  output       logic                          pslverr
);
  import mies_pkg::*;

  // ==========================================================
  // Helpers.
  function automatic logic [7:0] rotLeft(input logic [7:0] v,
                                         input logic in0);
    rotLeft = {v[6:0], in0};
  endfunction : rotLeft
  function automatic logic [7:0] rotRight(input logic [7:0] v,
                                          input logic in7);
    rotRight = {in7, v[7:1]};
  endfunction : rotRight
  function automatic logic inRange(input logic [7:0] a);
    inRange = (a < 8'(MEM_DEPTH));
  endfunction : inRange
  // Stack slot below p; wraps the same way a push does.
  function automatic logic [SP_W-1:0] prevSlot(input logic [SP_W-1:0] p);
    prevSlot = (p == '0) ? SP_W'(STACK_DEPTH - 1) : p - 3'h1;
  endfunction : prevSlot

  // ==========================================================
  // State.
  logic [7:0]        dataMem [MEM_DEPTH];
  logic [PC_W-1:0]   stackMem [STACK_DEPTH];
  logic [SP_W-1:0]   stackPtr;
  mies_instr_type    instr;
  logic              fetchValid;
  logic [7:0]        acc;
  mies_status_type   stat;
  logic              runEnable;
  logic [7:0]        memAddr;
  logic [WDT_PRE_W-1:0] wdtPrescale;
  logic [WDT_CNT_W-1:0] wdtCount;
  logic              step;
  logic              exec;
  logic [7:0]        rdData;
  logic [7:0]        next_acc;
  mies_status_type   next_stat;
  logic              memWr;
  logic [7:0]        memWrData;
  logic              pcLoad;
  logic [PC_W-1:0]   pcTarget;
  logic              doPush;
  logic              doPop;
  logic              powerDown;
  logic              irqReturn;
  logic              wdtExpire;
  logic              apbWrite;
  logic              apbRead;
  assign step   = runEnable && !coreHalted;
  assign exec   = step && fetchValid;
  assign rdData = inRange(instr.operand) ? dataMem[instr.operand] : 8'h00;
  assign wdtExpire = step && (&wdtPrescale) && (&wdtCount);
  assign apbWrite = psel && penable && pready && pwrite;
  assign apbRead  = psel && !penable;

  // ==========================================================
  // Execute decode.
  always_comb begin
    next_acc  = acc;
    next_stat = stat;
    memWr     = 1'b0;
    memWrData = rdData;
    pcLoad    = 1'b0;
    pcTarget  = progAddr;
    doPush    = 1'b0;
    doPop     = 1'b0;
    powerDown = 1'b0;
    irqReturn = 1'b0;
    unique case (instr.opClass)
      MIES_CLASS_MEM: begin
        case (instr.sub)
          SUB_ADD_ONE: begin
            memWr = 1'b1; // RULE_04
            memWrData = rdData + 8'h01;
            next_stat.zero = (memWrData == 8'h00);
          end
          SUB_ADD_ONE_ACC: begin
            next_acc = rdData + 8'h01; // RULE_05
            next_stat.zero = (next_acc == 8'h00);
          end
          SUB_COPY_TO_ACC: next_acc = rdData; // RULE_07
          SUB_COPY_TO_MEM: begin
            memWr = 1'b1; // RULE_09
            memWrData = acc;
          end
          SUB_OR_ACC: begin
            next_acc = acc | rdData; // RULE_11
            next_stat.zero = (next_acc == 8'h00);
          end
          SUB_OR_MEM: begin
            memWr = 1'b1; // RULE_12
            memWrData = acc | rdData;
            next_stat.zero = (memWrData == 8'h00);
          end
          SUB_ROT_L: begin
            memWr = 1'b1; // RULE_16
            memWrData = rotLeft(rdData, rdData[7]);
          end
          SUB_ROT_L_ACC: next_acc = rotLeft(rdData, rdData[7]); // RULE_17
          SUB_ROT_LC: begin
            memWr = 1'b1; // RULE_18
            memWrData = rotLeft(rdData, stat.carry);
            next_stat.carry = rdData[7];
          end
          SUB_ROT_LC_ACC: begin
            next_acc = rotLeft(rdData, stat.carry); // RULE_19
            next_stat.carry = rdData[7];
          end
          SUB_ROT_R: begin
            memWr = 1'b1; // RULE_20
            memWrData = rotRight(rdData, rdData[0]);
          end
          SUB_ROT_R_ACC: next_acc = rotRight(rdData, rdData[0]); // RULE_21
          SUB_ROT_RC: begin
            memWr = 1'b1; // RULE_22
            memWrData = rotRight(rdData, stat.carry);
            next_stat.carry = rdData[0];
          end
          SUB_ROT_RC_ACC: begin
            next_acc = rotRight(rdData, stat.carry);
            next_stat.carry = rdData[0];
          end
          default: ;
        endcase
      end
      MIES_CLASS_IMM: begin
        case (instr.sub)
          SUB_COPY_IMM: next_acc = instr.operand; // RULE_08
          SUB_OR_IMM: begin
            next_acc = acc | instr.operand; // RULE_11
            next_stat.zero = (next_acc == 8'h00);
          end
          SUB_RET_IMM: begin
            next_acc = instr.operand; // RULE_14
            doPop    = 1'b1;
          end
          default: ;
        endcase
      end
      MIES_CLASS_JUMP: begin
        pcLoad   = 1'b1; // RULE_06
        pcTarget = {instr.sub, instr.operand};
      end
      MIES_CLASS_CALL: begin
        pcLoad   = 1'b1;
        pcTarget = {instr.sub, instr.operand};
        doPush   = 1'b1;
      end
      MIES_CLASS_MISC: begin
        case (instr.sub)
          SUB_POWER_DOWN: begin
            powerDown = 1'b1;
            next_stat.sleepEntered   = 1'b1; // RULE_02
            next_stat.watchdogExpiry = 1'b0; // RULE_02
          end
          SUB_RET: doPop = 1'b1; // RULE_13
          SUB_IRQ_RET: begin
            doPop     = 1'b1; // RULE_15
            irqReturn = 1'b1;
          end
          default: ; // RULE_10
        endcase
      end
      default: ;
    endcase
    if (doPop) begin
      pcLoad   = 1'b1;
      pcTarget = stackMem[prevSlot(stackPtr)];
    end
  end

  // ==========================================================
  // Fetch pipeline and program counter.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      progAddr   <= '0;
      fetchValid <= 1'b0;
      instr      <= '0;
    end else if (exec && pcLoad) begin
      progAddr   <= pcTarget; // RULE_23
      fetchValid <= 1'b0;
    end else if (exec && powerDown) begin
      fetchValid <= 1'b0; // RULE_01
    end else if (step) begin
      instr      <= mies_instr_type'(progWord);
      progAddr   <= progAddr + 12'h001; // RULE_10
      fetchValid <= 1'b1;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      coreHalted <= 1'b0;
    end else if (exec && powerDown) begin
      coreHalted <= 1'b1; // RULE_01
    end else if (wakeUp) begin
      coreHalted <= 1'b0;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stackPtr <= '0;
    end else if (exec && doPush) begin
      stackMem[stackPtr] <= progAddr;
      stackPtr <= (stackPtr == SP_W'(STACK_DEPTH - 1)) ? '0
                                                       : stackPtr + 3'h1;
    end else if (exec && doPop) begin
      stackPtr <= prevSlot(stackPtr); // RULE_13
    end
  end

  // ==========================================================
  // Accumulator, data memory, flags.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc <= 8'h00;
    end else if (exec) begin
      acc <= next_acc;
    end
  end
  always_ff @(posedge clk) begin
    if (exec && memWr && inRange(instr.operand)) begin
      dataMem[instr.operand] <= memWrData;
    end else if (apbWrite && paddr == REG_MEM_DATA && inRange(memAddr)) begin
      dataMem[memAddr] <= pwdata[7:0];
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stat <= STATUS_RESET;
    end else begin
      if (exec) begin
        stat <= next_stat;
      end else if (apbWrite && paddr == REG_STATUS) begin
        stat <= mies_status_type'(pwdata[5:0]);
      end
      if (wdtExpire) begin
        stat.watchdogExpiry <= 1'b1;
      end
    end
  end
  // A power down restarts the watchdog from zero.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wdtPrescale <= '0;
      wdtCount    <= '0;
    end else if (exec && powerDown) begin
      wdtPrescale <= '0; // RULE_03
      wdtCount    <= '0; // RULE_03
    end else if (step) begin
      wdtPrescale <= wdtPrescale + 8'h01;
      if (&wdtPrescale) begin
        wdtCount <= wdtCount + 8'h01;
      end
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      globalIrqEnable <= 1'b0;
    end else if (exec && irqReturn) begin
      globalIrqEnable <= 1'b1; // RULE_15
    end else if (apbWrite && paddr == REG_IRQ_CTRL) begin
      globalIrqEnable <= pwdata[IRQ_GLOBAL_EN_BIT];
    end
  end

  // ==========================================================
  // APB slave, one wait-free access phase.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      runEnable <= 1'b0;
      memAddr   <= 8'h00;
    end else if (apbWrite) begin
      if (paddr == REG_CTRL) begin
        runEnable <= pwdata[CTRL_RUN_BIT];
      end
      if (paddr == REG_MEM_ADDR) begin
        memAddr <= pwdata[7:0];
      end
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apbRead;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (apbRead) begin
        unique case (paddr)
          REG_CTRL:     prdata <= 32'(runEnable);
          REG_STATUS:   prdata <= 32'(stat);
          REG_ACC:      prdata <= 32'(acc);
          REG_PC:       prdata <= 32'(progAddr);
          REG_IRQ_CTRL: prdata <= 32'(globalIrqEnable);
          REG_MEM_ADDR: prdata <= 32'(memAddr);
          REG_MEM_DATA:
            prdata <= inRange(memAddr) ? 32'(dataMem[memAddr]) : 32'h0;
          default:      pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  function automatic logic isOp(input mies_instr_type i,
                                input mies_class_type c,
                                input logic [3:0] s);
    isOp = (i.opClass == c) && (i.sub == s);
  endfunction : isOp
  sequence seqFlushed;
    !fetchValid;
  endsequence
  sequence seqRefilled;
    fetchValid || !step;
  endsequence

  chk_halt_flags: assert property ( // RULE_01
    exec && isOp(instr, MIES_CLASS_MISC, SUB_POWER_DOWN) |=>
      coreHalted && stat.sleepEntered && !stat.watchdogExpiry
      && progAddr == $past(progAddr))
    else $error("power down did not halt with correct flags");
  chk_halt_wdt: assert property ( // RULE_03
    exec && powerDown |=> wdtCount == 8'h00 && wdtPrescale == 8'h00
      && acc == $past(acc))
    else $error("power down did not clear the watchdog");
  chk_inc_mem: assert property ( // RULE_04
    exec && isOp(instr, MIES_CLASS_MEM, SUB_ADD_ONE)
      && inRange(instr.operand) |=>
      dataMem[$past(instr.operand)] == 8'($past(rdData) + 8'h01)
      && stat.carry == $past(stat.carry))
    else $error("add one did not update the memory byte");
  chk_jump_flush: assert property ( // RULE_06
    exec && instr.opClass == MIES_CLASS_JUMP |=>
      (progAddr == $past(pcTarget)) and (seqFlushed ##1 seqRefilled))
    else $error("jump did not reload and flush");
  chk_copy_imm: assert property ( // RULE_08
    exec && isOp(instr, MIES_CLASS_IMM, SUB_COPY_IMM) |=>
      acc == $past(instr.operand) && stat == $past(stat))
    else $error("literal copy wrong or flags changed");
  chk_idle_adv: assert property ( // RULE_10
    exec && isOp(instr, MIES_CLASS_MISC, SUB_IDLE) |=>
      progAddr == 12'($past(progAddr) + 12'h001) && $stable(acc))
    else $error("idle changed state");
  chk_ret_cycles: assert property ( // RULE_13
    exec && isOp(instr, MIES_CLASS_MISC, SUB_RET) |=>
      (seqFlushed and $stable(stat)) ##1 seqRefilled)
    else $error("return did not take two cycles");
  chk_irq_ret: assert property ( // RULE_15
    exec && irqReturn |=> globalIrqEnable)
    else $error("interrupt return did not enable interrupts");
  chk_rlc_carry: assert property ( // RULE_18
    exec && isOp(instr, MIES_CLASS_MEM, SUB_ROT_LC) |=>
      stat.carry == $past(rdData[7]))
    else $error("left rotate through carry lost bit 7");
  chk_rr_acc: assert property ( // RULE_21
    exec && isOp(instr, MIES_CLASS_MEM, SUB_ROT_R_ACC) |=>
      acc == {$past(rdData[0]), $past(rdData[7:1])} && $stable(stat))
    else $error("right rotate to accumulator wrong");

endmodule : mies_core

/* File: mies_tb.sv */
`timescale 1ns/1ps
module testbench;
  import mies_pkg::*;

  // ==========================================================
  // Signals and design under test.
  logic              clk;
  logic              reset;
  logic [PC_W-1:0]   progAddr;
  logic [WORD_W-1:0] progWord;
  logic              wakeUp;
  logic              coreHalted;
  logic              globalIrqEnable;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [WORD_W-1:0] rom [0:4095];
  logic [31:0]       rdData;
  logic              rdErr;
  int                failCount;
  int                compares;

  // The program store answers combinationally, like the real fetch port.
  assign progWord = rom[progAddr];

  mies_core uut (
    .clk             (clk),
    .reset           (reset),
    .progAddr        (progAddr),
    .progWord        (progWord),
    .wakeUp          (wakeUp),
    .coreHalted      (coreHalted),
    .globalIrqEnable (globalIrqEnable),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // Checking and bus tasks.
  task check(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task report_and_stop;
    if (failCount == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task give_up;
    failCount++;
    report_and_stop();
  endtask : give_up

  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) give_up();
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd_chk(input string name, input logic [7:0] addr,
              input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(name, rdData, exp);
  endtask : rd_chk

  task mem_set(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, REG_MEM_ADDR, {24'h0, a});
    apb(1'b1, REG_MEM_DATA, {24'h0, d});
  endtask : mem_set

  task mem_chk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b1, REG_MEM_ADDR, {24'h0, a});
    rd_chk($sformatf("mem %h", a), REG_MEM_DATA, {24'h0, exp});
  endtask : mem_chk

  // Waits for power down and checks where the counter rests.
  task wait_halt(input logic [PC_W-1:0] expPc);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (coreHalted !== 1'b1 && n < 500);
    if (coreHalted !== 1'b1) give_up();
    check("haltPc", {20'h0, progAddr}, {20'h0, expPc});
  endtask : wait_halt

  task resume(input logic [7:0] statusVal);
    apb(1'b1, REG_STATUS, {24'h0, statusVal});
    @(posedge clk);
    wakeUp <= 1'b1;
    @(posedge clk);
    wakeUp <= 1'b0;
  endtask : resume

  function automatic logic [WORD_W-1:0] mk(input mies_class_type c,
                                           input logic [3:0] s,
                                           input logic [7:0] o);
    return {c, s, o};
  endfunction : mk

  // ==========================================================
  // Program and main sequence.
  initial begin
    reset = 1'b1;
    wakeUp = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    failCount = 0;
    compares = 0;
    for (int i = 0; i < 4096; i++) rom[i] = mk(MIES_CLASS_MISC, SUB_IDLE, 8'h0);
    rom[0]  = mk(MIES_CLASS_MEM, SUB_ADD_ONE, 8'h20);
    rom[2]  = mk(MIES_CLASS_MEM, SUB_ADD_ONE_ACC, 8'h21);
    rom[3]  = mk(MIES_CLASS_MEM, SUB_COPY_TO_MEM, 8'h28);
    rom[4]  = mk(MIES_CLASS_MEM, SUB_OR_MEM, 8'h22);
    rom[5]  = mk(MIES_CLASS_MEM, SUB_OR_ACC, 8'h28);
    rom[6]  = mk(MIES_CLASS_IMM, SUB_COPY_IMM, 8'h00);
    rom[7]  = mk(MIES_CLASS_MEM, SUB_COPY_TO_MEM, 8'h29);
    rom[8]  = mk(MIES_CLASS_IMM, SUB_OR_IMM, 8'h00);
    rom[9]  = mk(MIES_CLASS_MEM, SUB_COPY_TO_ACC, 8'h21);
    rom[10] = mk(MIES_CLASS_MEM, SUB_COPY_TO_MEM, 8'h2a);
    rom[11] = mk(MIES_CLASS_MISC, SUB_POWER_DOWN, 8'h0);
    rom[12] = mk(MIES_CLASS_MEM, SUB_ROT_L, 8'h23);
    rom[13] = mk(MIES_CLASS_MEM, SUB_ROT_L_ACC, 8'h24);
    rom[14] = mk(MIES_CLASS_MEM, SUB_COPY_TO_MEM, 8'h2c);
    rom[15] = mk(MIES_CLASS_MEM, SUB_ROT_LC, 8'h25);
    rom[16] = mk(MIES_CLASS_MEM, SUB_ROT_LC_ACC, 8'h21);
    rom[17] = mk(MIES_CLASS_MEM, SUB_COPY_TO_MEM, 8'h2b);
    rom[18] = mk(MIES_CLASS_MEM, SUB_ROT_R, 8'h26);
    rom[19] = mk(MIES_CLASS_MEM, SUB_ROT_RC, 8'h27);
    rom[20] = mk(MIES_CLASS_MEM, SUB_ROT_R_ACC, 8'h24);
    rom[21] = mk(MIES_CLASS_MISC, SUB_POWER_DOWN, 8'h0);
    rom[22] = mk(MIES_CLASS_JUMP, 4'h0, 8'h40);
    // Words after a counter reload must never execute.
    rom[23] = mk(MIES_CLASS_MEM, SUB_ADD_ONE, 8'h28);
    rom[12'h40] = mk(MIES_CLASS_CALL, 4'h0, 8'h50);
    rom[12'h41] = mk(MIES_CLASS_CALL, 4'h0, 8'h58);
    rom[12'h42] = mk(MIES_CLASS_CALL, 4'h0, 8'h60);
    rom[12'h43] = mk(MIES_CLASS_MISC, SUB_POWER_DOWN, 8'h0);
    rom[12'h50] = mk(MIES_CLASS_MISC, SUB_RET, 8'h0);
    rom[12'h58] = mk(MIES_CLASS_IMM, SUB_RET_IMM, 8'h5a);
    rom[12'h60] = mk(MIES_CLASS_MISC, SUB_IRQ_RET, 8'h0);
    foreach (rom[i]) begin
      if (i == 12'h51 || i == 12'h59 || i == 12'h61) begin
        rom[i] = mk(MIES_CLASS_IMM, SUB_OR_IMM, 8'h80);
      end
    end
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd_chk("status", REG_STATUS, 32'h0);
    rd_chk("acc", REG_ACC, 32'h0);
    rd_chk("pc", REG_PC, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    check("slverr", {31'h0, rdErr}, 32'h1);
    apb(1'b1, REG_IRQ_CTRL, 32'h1);
    rd_chk("irqCtrl", REG_IRQ_CTRL, 32'h1);
    apb(1'b1, REG_IRQ_CTRL, 32'h0);
    mem_set(8'h20, 8'hff);
    mem_set(8'h21, 8'h7f);
    for (int a = 8'h22; a <= 8'h25; a++) mem_set(a[7:0], 8'h81);
    mem_set(8'h26, 8'h01);
    mem_set(8'h27, 8'h01);
    mem_set(8'h28, 8'h00);
    for (int a = 8'h29; a <= 8'h2c; a++) mem_set(a[7:0], 8'h55);
    // Moves, increments and OR, entered with the expiry flag set.
    apb(1'b1, REG_STATUS, 32'h20);
    apb(1'b1, REG_CTRL, 32'h1);
    wait_halt(12'd12);
    rd_chk("acc", REG_ACC, 32'h7f);
    rd_chk("status", REG_STATUS, 32'h14);
    mem_chk(8'h20, 8'h00);
    mem_chk(8'h21, 8'h7f);
    mem_chk(8'h22, 8'h81);
    mem_chk(8'h28, 8'h80);
    mem_chk(8'h29, 8'h00);
    mem_chk(8'h2a, 8'h7f);
    // Rotates, entered with carry set.
    resume(8'h01);
    wait_halt(12'd22);
    rd_chk("acc", REG_ACC, 32'hc0);
    rd_chk("status", REG_STATUS, 32'h11);
    mem_chk(8'h23, 8'h03);
    mem_chk(8'h24, 8'h81);
    mem_chk(8'h2c, 8'h03);
    mem_chk(8'h25, 8'h03);
    mem_chk(8'h21, 8'h7f);
    mem_chk(8'h2b, 8'hff);
    mem_chk(8'h26, 8'h80);
    mem_chk(8'h27, 8'h00);
    // Jump, call and the three returns.
    resume(8'h00);
    wait_halt(12'h044);
    rd_chk("acc", REG_ACC, 32'h5a);
    rd_chk("status", REG_STATUS, 32'h10);
    rd_chk("irqCtrl", REG_IRQ_CTRL, 32'h1);
    check("irqEn", {31'h0, globalIrqEnable}, 32'h1);
    mem_chk(8'h28, 8'h80);
    report_and_stop();
  end

endmodule : testbench
